// file: pbc_pkg.sv
// ==================================================================
// Shared constants for the pre-pit block codec
package pbc_pkg;

   // ==================================================================
   // Block and frame geometry
   localparam logic [3:0] FRM_LAST = 4'h_F;        // Last relative frame number
   localparam logic [3:0] BIT_LAST = 4'h_C;        // Last bit position of a frame
   localparam logic [1:0] POS_LAST = 2'h_2;        // Last position of a bit pattern
   localparam logic [3:0] PFX_LAST = 4'h_B;        // Last position of block sync prefix
   localparam logic [11:0] PFX_PATTERN = 12'h_DB4; // Block sync prefix, no run of three ones
   localparam logic [2:0] TRIP_SYNC = 3'h_7;       // Sync position pattern 111
   localparam logic [2:0] TRIP_ONE = 3'h_5;        // Data ONE 101
   localparam logic [2:0] TRIP_ZERO = 3'h_4;       // Data ZERO 100
   localparam logic [9:0] BLK_POSITIONS = 10'h_27C; // 12 + 16 * 13 * 3 positions
   localparam logic [15:0] MASK_FULL = 16'h_FFFF;

   // ==================================================================
   // Address constants
   localparam logic [3:0] ADDR_TOP = 4'h_F;              // Upper nibble of block address
   localparam logic [23:0] DZ_START_PSN = 24'h_03_0000;  // First groove sector of data zone
   localparam logic [23:0] DZ_START_ADDR = 24'h_FF_CFFF; // Block address there
   localparam logic [23:0] LEADIN_FIRST = 24'h_FF_DBBB;  // Start of identifier cycle
   localparam logic [23:0] LEADIN_LAST = 24'h_FF_D000;   // End of lead-in
   localparam logic [23:0] ID0_FIRST = 24'h_FF_D003;     // First identifier-0 lead-in block
   localparam logic [23:0] FID_CYCLE = 24'h_00_0005;     // Identifiers 1 to 5 repeat
   localparam logic [7:0] FID_ADDR_LAYER = 8'h_00;       // address_layer_block identifier

   // ==================================================================
   // Galois field and generator (x+1)(x+a)(x+a^2)
   localparam logic [7:0] GF_POLY = 8'h_1D; // x^8+x^4+x^3+x^2+1 without x^8
   localparam logic [7:0] GEN_C2 = 8'h_07;
   localparam logic [7:0] GEN_C1 = 8'h_0E;
   localparam logic [7:0] GEN_C0 = 8'h_08;

   // ==================================================================
   // State machines
   typedef enum logic [1:0] {PBC_E_IDLE, PBC_E_PREFIX, PBC_E_FRAME} pbc_enc_state_t;
   typedef enum logic [1:0] {PBC_D_HUNT, PBC_D_BITS, PBC_D_SYNC} pbc_dec_state_t;

endpackage

// file: pbc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Two-stage synchroniser for pin inputs
module pbc_sync2 #(
   parameter int W = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// file: pbc_parity.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Three-byte remainder of msg(x)*x^3 over the generator, seven bytes in
module pbc_parity (
   input wire logic [55:0] msg,
   output logic [23:0] par
);
   import pbc_pkg::*;

   logic [23:0] st [8];

   // Multiply two field elements
   function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] t;
      p = '0;
      t = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            p = p ^ t;
         end
         t = {t[6:0], 1'b0} ^ (t[7] ? GF_POLY : 8'h_00);
      end
      return p;
   endfunction

   // Divider steps, first byte most significant; leading zeros leave it unchanged
   assign st[0] = '0;
   for (genvar g = 0; g < 7; g++) begin : g_step
      logic [7:0] fb;
      assign fb = msg[55 - 8*g -: 8] ^ st[g][23:16];
      assign st[g+1] = {st[g][15:8] ^ gf_mul(fb, GEN_C2),
                        st[g][7:0] ^ gf_mul(fb, GEN_C1),
                        gf_mul(fb, GEN_C0)};
   end

   assign par = st[7];
endmodule
`default_nettype wire

// file: pbc_codec.sv
// Behaviour
// R1: A block holds 16 frames numbered 0000 to 1111.
// R2: Frame number equals low four bits of the groove sector number.
// R3: Frame number has no check; decoder uses it as received.
// R4: Block address is inverted sector number bits 23 to 4.
// R5: First data zone block address is FFCFFF.
// R6: Frames 0-2 carry address bytes MSB first, frames 3-5 its parity.
// R7: Part A parity is I(x)*x^3 mod (x+1)(x+a)(x+a^2).
// R8: Field arithmetic uses GF(256) with x^8+x^4+x^3+x^2+1.
// R9: Part B parity covers frames 6 to 12, same generator.
// R10: Frame 6 carries the field identifier.
// R11: Identifier 0 address/layer, 1 and 2 limits, 3 and 4 maker, 5 reserved.
// R12: Lead-in cycles identifiers 1-5 from FFDBBB, then identifier 0 to FFD000.
// R13: Identifier 0: frames 7-9 address, 10 layer, 11 and 12 zero.
// R14: Frame is 13 bits: sync, 4-bit frame number, data byte MSB first.
// R15: Encoder puts a sync prefix before the block.
// R16: Data ONE is 101, ZERO is 100, sync position is 111.
// R17: Layer byte top bit is layer, other bits zero.
// R18: Decoder checks both parity groups with separate error flags.
`timescale 1ns/1ps
`default_nettype none
module pbc_codec (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enc_start,
   input wire logic [23:0] enc_psn,
   input wire logic enc_auto,
   input wire logic [7:0] enc_field_id,
   input wire logic enc_layer,
   input wire logic [47:0] enc_info,
   output logic enc_busy,
   output logic enc_pos_valid,
   output logic enc_pos,
   output logic enc_block_done,
   input wire logic rx_pos_valid,
   input wire logic rx_pos,
   output logic dec_block_valid,
   output logic [23:0] dec_addr,
   output logic [7:0] dec_field_id,
   output logic [47:0] dec_info,
   output logic dec_layer,
   output logic dec_err_a,
   output logic dec_err_b,
   output logic dec_frame_err
);
   import pbc_pkg::*;

   // ==================================================================
   // Encoder block assembly
   logic [23:0] enc_addr;
   logic [23:0] li_off;
   logic [23:0] li_mod;
   logic [7:0] fid_sel;
   logic [7:0] ld [16];
   logic [23:0] enc_par_a;
   logic [23:0] enc_par_b;

   assign enc_addr = {ADDR_TOP, ~enc_psn[23:4]}; // [R4] [R5]
   assign li_off = LEADIN_FIRST - enc_addr;
   assign li_mod = li_off % FID_CYCLE;

   // Identifier choice: lead-in cycle in auto mode, identifier 0 outside the cycle range; else caller's choice
   always_comb begin
      fid_sel = enc_field_id;
      if (enc_auto) begin
         if (enc_addr <= LEADIN_FIRST && enc_addr > ID0_FIRST) begin
            fid_sel = 8'(li_mod) + 8'h_01; // [R12] [R11]
         end else begin
            fid_sel = FID_ADDR_LAYER; // [R12]
         end
      end
   end

   // Information bytes of both parts
   always_comb begin
      ld[0] = enc_addr[23:16]; // [R6]
      ld[1] = enc_addr[15:8];
      ld[2] = enc_addr[7:0];
      ld[3] = enc_par_a[23:16]; // [R7]
      ld[4] = enc_par_a[15:8];
      ld[5] = enc_par_a[7:0];
      ld[6] = fid_sel; // [R10]
      for (int j = 0; j < 6; j++) begin
         ld[7+j] = enc_info[47 - 8*j -: 8];
      end
      if (fid_sel == FID_ADDR_LAYER) begin
         ld[7] = enc_addr[23:16]; // [R13]
         ld[8] = enc_addr[15:8];
         ld[9] = enc_addr[7:0];
         ld[10] = {enc_layer, 7'h_00}; // [R17]
         ld[11] = 8'h_00;
         ld[12] = 8'h_00;
      end
      ld[13] = enc_par_b[23:16]; // [R9]
      ld[14] = enc_par_b[15:8];
      ld[15] = enc_par_b[7:0];
   end

   // Parity of part A (padded with zeros) and part B
   pbc_parity u_enc_par_a (
      .msg({32'h_0000_0000, enc_addr}),
      .par(enc_par_a)
   ); // [R7] [R8]

   pbc_parity u_enc_par_b (
      .msg({ld[6], ld[7], ld[8], ld[9], ld[10], ld[11], ld[12]}),
      .par(enc_par_b)
   ); // [R9] [R8]

   // ==================================================================
   // Encoder serialiser
   pbc_enc_state_t es_r, es_nxt;
   logic [7:0] eblk_r [16];
   logic [7:0] eblk_nxt [16];
   logic [3:0] frm_r, frm_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [1:0] pos_r, pos_nxt;
   logic enc_busy_r, enc_busy_nxt;
   logic enc_pv_r, enc_pv_nxt;
   logic enc_pos_r, enc_pos_nxt;
   logic enc_done_r, enc_done_nxt;
   logic [11:0] eword;

   assign eword = {frm_r, eblk_r[frm_r]}; // [R14] [R2]

   // Next state of encoder
   always_comb begin
      es_nxt = es_r;
      eblk_nxt = eblk_r;
      frm_nxt = frm_r;
      bit_nxt = bit_r;
      pos_nxt = pos_r;
      enc_busy_nxt = enc_busy_r;
      enc_pv_nxt = 1'b0;
      enc_pos_nxt = 1'b0;
      enc_done_nxt = 1'b0;
      case (es_r)
         PBC_E_IDLE: begin
            if (enc_start) begin
               eblk_nxt = ld;
               es_nxt = PBC_E_PREFIX;
               bit_nxt = '0;
               enc_busy_nxt = 1'b1;
            end
         end
         PBC_E_PREFIX: begin
            enc_pv_nxt = 1'b1;
            enc_pos_nxt = PFX_PATTERN[PFX_LAST - bit_r]; // [R15]
            bit_nxt = bit_r + 4'h_1;
            if (bit_r == PFX_LAST) begin
               es_nxt = PBC_E_FRAME;
               frm_nxt = '0; // [R1]
               bit_nxt = '0;
               pos_nxt = '0;
            end
         end
         PBC_E_FRAME: begin
            enc_pv_nxt = 1'b1;
            if (bit_r == 4'h_0) begin
               enc_pos_nxt = 1'b1; // [R16]
            end else if (pos_r == 2'h_0) begin
               enc_pos_nxt = 1'b1; // [R16]
            end else if (pos_r == 2'h_1) begin
               enc_pos_nxt = 1'b0;
            end else begin
               enc_pos_nxt = eword[BIT_LAST - bit_r]; // [R14] [R3]
            end
            pos_nxt = pos_r + 2'h_1;
            if (pos_r == POS_LAST) begin
               pos_nxt = '0;
               bit_nxt = bit_r + 4'h_1;
               if (bit_r == BIT_LAST) begin
                  bit_nxt = '0;
                  frm_nxt = frm_r + 4'h_1; // [R1] [R2]
                  if (frm_r == FRM_LAST) begin
                     es_nxt = PBC_E_IDLE;
                     enc_busy_nxt = 1'b0;
                     enc_done_nxt = 1'b1;
                  end
               end
            end
         end
         default: begin
            es_nxt = PBC_E_IDLE;
            enc_busy_nxt = 1'b0;
         end
      endcase
   end

   // Encoder registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         es_r <= PBC_E_IDLE;
         for (int j = 0; j < 16; j++) begin
            eblk_r[j] <= 8'h_00;
         end
         frm_r <= '0;
         bit_r <= '0;
         pos_r <= '0;
         enc_busy_r <= 1'b0;
         enc_pv_r <= 1'b0;
         enc_pos_r <= 1'b0;
         enc_done_r <= 1'b0;
      end else begin
         es_r <= es_nxt;
         eblk_r <= eblk_nxt;
         frm_r <= frm_nxt;
         bit_r <= bit_nxt;
         pos_r <= pos_nxt;
         enc_busy_r <= enc_busy_nxt;
         enc_pv_r <= enc_pv_nxt;
         enc_pos_r <= enc_pos_nxt;
         enc_done_r <= enc_done_nxt;
      end
   end

   assign enc_busy = enc_busy_r;
   assign enc_pos_valid = enc_pv_r;
   assign enc_pos = enc_pos_r;
   assign enc_block_done = enc_done_r;

   // ==================================================================
   // Decoder: pin synchroniser and framing
   logic rx_v_s;
   logic rx_p_s;

   pbc_sync2 #(.W(2)) u_rx_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d({rx_pos_valid, rx_pos}),
      .q({rx_v_s, rx_p_s})
   );

   pbc_dec_state_t ds_r, ds_nxt;
   logic [1:0] sh_r, sh_nxt;
   logic [1:0] dpos_r, dpos_nxt;
   logic [3:0] dbit_r, dbit_nxt;
   logic [11:0] dword_r, dword_nxt;
   logic [7:0] rblk_r [16];
   logic [7:0] rblk_nxt [16];
   logic [15:0] mask_r, mask_nxt;
   logic fin_r, fin_nxt;
   logic ferr_r, ferr_nxt;
   logic [2:0] trip;
   logic [11:0] wnew;

   assign trip = {sh_r, rx_p_s};
   assign wnew = {dword_r[10:0], rx_p_s};

   // Next state of decoder
   always_comb begin
      ds_nxt = ds_r;
      sh_nxt = sh_r;
      dpos_nxt = dpos_r;
      dbit_nxt = dbit_r;
      dword_nxt = dword_r;
      rblk_nxt = rblk_r;
      mask_nxt = mask_r;
      fin_nxt = 1'b0;
      ferr_nxt = 1'b0;
      if (rx_v_s) begin
         sh_nxt = trip[1:0];
         dpos_nxt = dpos_r + 2'h_1;
         case (ds_r)
            PBC_D_HUNT: begin
               if (trip == TRIP_SYNC) begin
                  ds_nxt = PBC_D_BITS;
                  dbit_nxt = 4'h_1;
                  dpos_nxt = '0;
               end
            end
            PBC_D_BITS: begin
               if (dpos_r == POS_LAST) begin
                  dpos_nxt = '0;
                  dbit_nxt = dbit_r + 4'h_1;
                  dword_nxt = wnew;
                  if (trip != TRIP_ONE && trip != TRIP_ZERO) begin
                     ferr_nxt = 1'b1; // [R16]
                     ds_nxt = PBC_D_HUNT;
                  end else if (dbit_r == BIT_LAST) begin
                     rblk_nxt[wnew[11:8]] = wnew[7:0]; // [R3] [R14]
                     mask_nxt[wnew[11:8]] = 1'b1;
                     if (wnew[11:8] == FRM_LAST) begin
                        fin_nxt = 1'b1; // [R1]
                        sh_nxt = '0; // Drop tail before next prefix
                        ds_nxt = PBC_D_HUNT;
                     end else begin
                        ds_nxt = PBC_D_SYNC;
                     end
                  end
               end
            end
            PBC_D_SYNC: begin
               if (dpos_r == POS_LAST) begin
                  dpos_nxt = '0;
                  if (trip == TRIP_SYNC) begin
                     ds_nxt = PBC_D_BITS; // [R16]
                     dbit_nxt = 4'h_1;
                  end else begin
                     ferr_nxt = 1'b1;
                     ds_nxt = PBC_D_HUNT;
                  end
               end
            end
            default: begin
               ds_nxt = PBC_D_HUNT;
            end
         endcase
      end
      if (fin_r) begin
         mask_nxt = '0;
      end
   end

   // Decoder registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ds_r <= PBC_D_HUNT;
         sh_r <= '0;
         dpos_r <= '0;
         dbit_r <= '0;
         dword_r <= '0;
         for (int j = 0; j < 16; j++) begin
            rblk_r[j] <= 8'h_00;
         end
         mask_r <= '0;
         fin_r <= 1'b0;
         ferr_r <= 1'b0;
      end else begin
         ds_r <= ds_nxt;
         sh_r <= sh_nxt;
         dpos_r <= dpos_nxt;
         dbit_r <= dbit_nxt;
         dword_r <= dword_nxt;
         rblk_r <= rblk_nxt;
         mask_r <= mask_nxt;
         fin_r <= fin_nxt;
         ferr_r <= ferr_nxt;
      end
   end

   // ==================================================================
   // Decoder parity check and results
   logic [23:0] dec_par_a;
   logic [23:0] dec_par_b;

   pbc_parity u_dec_par_a (
      .msg({32'h_0000_0000, rblk_r[0], rblk_r[1], rblk_r[2]}),
      .par(dec_par_a)
   ); // [R18]

   pbc_parity u_dec_par_b (
      .msg({rblk_r[6], rblk_r[7], rblk_r[8], rblk_r[9], rblk_r[10], rblk_r[11], rblk_r[12]}),
      .par(dec_par_b)
   ); // [R18]

   logic dvalid_r;
   logic [23:0] daddr_r;
   logic [7:0] dfid_r;
   logic [47:0] dinfo_r;
   logic dlayer_r;
   logic derr_a_r;
   logic derr_b_r;
   logic dferr_r;

   // Result registers, refreshed one cycle after the last frame; frame error also one cycle after ferr_r
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dvalid_r <= 1'b0;
         daddr_r <= '0;
         dfid_r <= '0;
         dinfo_r <= '0;
         dlayer_r <= 1'b0;
         derr_a_r <= 1'b0;
         derr_b_r <= 1'b0;
         dferr_r <= 1'b0;
      end else begin
         dvalid_r <= fin_r;
         derr_a_r <= fin_r && (dec_par_a != {rblk_r[3], rblk_r[4], rblk_r[5]}); // [R18] [R7]
         derr_b_r <= fin_r && (dec_par_b != {rblk_r[13], rblk_r[14], rblk_r[15]}); // [R18] [R9]
         dferr_r <= ferr_r || (fin_r && mask_r != MASK_FULL);
         if (fin_r) begin
            daddr_r <= {rblk_r[0], rblk_r[1], rblk_r[2]}; // [R6]
            dfid_r <= rblk_r[6]; // [R10]
            dinfo_r <= {rblk_r[7], rblk_r[8], rblk_r[9], rblk_r[10], rblk_r[11], rblk_r[12]};
            dlayer_r <= rblk_r[10][7]; // [R17]
         end
      end
   end

   assign dec_block_valid = dvalid_r;
   assign dec_addr = daddr_r;
   assign dec_field_id = dfid_r;
   assign dec_info = dinfo_r;
   assign dec_layer = dlayer_r;
   assign dec_err_a = derr_a_r;
   assign dec_err_b = derr_b_r;
   assign dec_frame_err = dferr_r;

   // ==================================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic [9:0] pv_cnt_r;
   logic start_ok;

   assign start_ok = enc_start && es_r == PBC_E_IDLE;

   // Helper: positions emitted in the current burst
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pv_cnt_r <= '0;
      end else begin
         pv_cnt_r <= enc_pv_r ? pv_cnt_r + 10'h_001 : 10'h_000;
      end
   end

   a_addr_invert: assert property (start_ok |=> {eblk_r[0], eblk_r[1], eblk_r[2]}
      == {ADDR_TOP, ~$past(enc_psn[23:4])}) else $error("address not inverted"); // [R4] [R6]
   a_dz_start: assert property (start_ok && enc_psn == DZ_START_PSN |=>
      {eblk_r[0], eblk_r[1], eblk_r[2]} == DZ_START_ADDR) else $error("bad start addr"); // [R5]
   a_id0_layout: assert property (start_ok && fid_sel == FID_ADDR_LAYER |=>
      eblk_r[7] == eblk_r[0] && eblk_r[9] == eblk_r[2] && eblk_r[10][6:0] == 7'h_00
      && eblk_r[11] == 8'h_00 && eblk_r[12] == 8'h_00) else $error("id0 layout"); // [R13] [R17]
   a_leadin_first: assert property (start_ok && enc_auto && enc_addr == LEADIN_FIRST |=>
      eblk_r[6] == 8'h_01) else $error("lead-in cycle start"); // [R12]
   a_frame_step: assert property (es_r == PBC_E_FRAME && pos_r == POS_LAST && bit_r == BIT_LAST
      && frm_r != FRM_LAST |=> frm_r == $past(frm_r) + 4'h_1) else $error("frame step"); // [R1]
   a_sync_code: assert property (es_r == PBC_E_FRAME && bit_r == 4'h_0 |=> enc_pos_r
      ##1 enc_pos_r) else $error("sync position not 111"); // [R16] [R14]
   a_bit_code: assert property (es_r == PBC_E_FRAME && bit_r != 4'h_0 && pos_r == 2'h_0
      |=> enc_pos_r ##1 !enc_pos_r) else $error("bit pattern head"); // [R16]
   a_block_len: assert property ($fell(enc_pv_r) |-> pv_cnt_r == BLK_POSITIONS
      && $past(enc_done_r) == 1'b1) else $error("block length"); // [R15] [R1]
   a_done_pulse: assert property (enc_done_r |-> !enc_busy_r ##1 !enc_done_r)
      else $error("done not a pulse"); // [R1]
   a_err_flags: assert property ((dec_err_a || dec_err_b) |-> dec_block_valid)
      else $error("error without block"); // [R18]

   c_enc_block: cover property (start_ok ##[600:700] enc_done_r);
   c_dec_clean: cover property (dvalid_r && !derr_a_r && !derr_b_r && !dferr_r);
   c_dec_err_a: cover property (derr_a_r);
   c_dec_frame_err: cover property (dferr_r);
endmodule
`default_nettype wire

// file: pbc_channel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Pre-pit channel model: records one block, replays it to the pins
module pbc_channel_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic src_valid,
   input wire logic src_pos,
   input wire logic play,
   input wire logic slow,
   input wire logic [9:0] flip,
   output logic rx_pos_valid,
   output logic rx_pos,
   output logic busy
);
   logic mem [0:635];
   logic [9:0] wi;
   logic [9:0] ri;
   logic gap;
   // Record positions, then replay with optional gaps and one flipped position
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wi <= 10'h_000;
         ri <= 10'h_000;
         busy <= 1'b0;
         gap <= 1'b0;
         rx_pos_valid <= 1'b0;
         rx_pos <= 1'b0;
      end else begin
         if (src_valid) begin
            mem[wi] <= src_pos;
            wi <= (wi == 10'h_27B) ? 10'h_000 : wi + 10'h_001;
         end
         rx_pos_valid <= 1'b0;
         rx_pos <= ~rx_pos; // Idle line toggles, never a stale value
         if (play && !busy) begin
            busy <= 1'b1;
            ri <= 10'h_000;
            gap <= 1'b0;
         end else if (busy && gap) begin
            gap <= 1'b0;
         end else if (busy && ri == 10'h_27C) begin
            busy <= 1'b0;
         end else if (busy) begin
            rx_pos_valid <= 1'b1;
            rx_pos <= mem[ri] ^ (ri == flip); // Whole frames, 3 positions a bit
            ri <= ri + 10'h_001;
            gap <= slow;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pbc_pkg::*;
   // ==================================================================
   // Signals
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic enc_start = 1'b0;
   logic enc_auto = 1'b0;
   logic enc_layer = 1'b0;
   logic [23:0] enc_psn = 24'h_00_0000;
   logic [7:0] enc_field_id = 8'h_00;
   logic [47:0] enc_info = 48'h_0000_0000_0000;
   logic enc_busy, enc_pos_valid, enc_pos, enc_block_done, rx_pos_valid, rx_pos;
   logic dec_block_valid, dec_layer, dec_err_a, dec_err_b, dec_frame_err, m_busy;
   logic [23:0] dec_addr;
   logic [7:0] dec_field_id;
   logic [47:0] dec_info;
   logic play = 1'b0;
   logic slow = 1'b0;
   logic [9:0] flip = 10'h_3FF;
   logic cap [0:1023];
   logic [9:0] cn = 10'h_000;
   logic [9:0] dn = 10'h_000;
   logic fe_seen = 1'b0;
   logic bv_seen = 1'b0;
   logic [82:0] snap;
   int fails = 0;
   int cmp_count = 0;

   // Clock of 20 ns
   always #10 clock = ~clock;

   pbc_codec u_pbc_codec (.clock(clock), .rst_n(rst_n), .enc_start(enc_start),
      .enc_psn(enc_psn), .enc_auto(enc_auto), .enc_field_id(enc_field_id),
      .enc_layer(enc_layer), .enc_info(enc_info), .enc_busy(enc_busy),
      .enc_pos_valid(enc_pos_valid), .enc_pos(enc_pos), .enc_block_done(enc_block_done),
      .rx_pos_valid(rx_pos_valid), .rx_pos(rx_pos), .dec_block_valid(dec_block_valid),
      .dec_addr(dec_addr), .dec_field_id(dec_field_id), .dec_info(dec_info),
      .dec_layer(dec_layer), .dec_err_a(dec_err_a), .dec_err_b(dec_err_b),
      .dec_frame_err(dec_frame_err));

   pbc_channel_model u_pbc_channel_model (.clock(clock), .rst_n(rst_n),
      .src_valid(enc_pos_valid), .src_pos(enc_pos), .play(play), .slow(slow),
      .flip(flip), .rx_pos_valid(rx_pos_valid), .rx_pos(rx_pos), .busy(m_busy));

   // Capture encoder positions and decoder results
   always @(posedge clock) begin
      if (enc_pos_valid === 1'b1) begin
         cap[cn] <= enc_pos;
         cn <= cn + 10'h_001;
      end
      if (enc_block_done === 1'b1) dn <= cn;
      if (dec_frame_err === 1'b1) fe_seen <= 1'b1;
      if (dec_block_valid === 1'b1) begin
         bv_seen <= 1'b1;
         snap <= {dec_err_a, dec_err_b, dec_layer, dec_field_id, dec_addr, dec_info};
      end
   end

   // ==================================================================
   // Reference arithmetic
   function automatic logic [7:0] gm(input logic [7:0] x, input logic [7:0] y);
      logic [7:0] p;
      int i;
      p = 8'h_00;
      for (i = 7; i >= 0; i--) begin
         p = {p[6:0], 1'b0} ^ (p[7] ? 8'h_1D : 8'h_00);
         if (y[i]) p = p ^ x;
      end
      return p;
   endfunction

   // Remainder of n bytes times x^3 over (x+1)(x+a)(x+a^2)
   function automatic logic [23:0] rs(input logic [55:0] m, input int n);
      logic [7:0] r2, r1, r0, fb;
      int i;
      r2 = 8'h_00;
      r1 = 8'h_00;
      r0 = 8'h_00;
      for (i = 0; i < n; i++) begin
         fb = m[55-8*i -: 8] ^ r2;
         r2 = r1 ^ gm(fb, 8'h_07);
         r1 = r0 ^ gm(fb, 8'h_0E);
         r0 = gm(fb, 8'h_08);
      end
      return {r2, r1, r0};
   endfunction

   // ==================================================================
   // Checking and closing
   task automatic chk(input logic [83:0] seen, input logic [83:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Encode one block, check the positions, replay it and check the decoder
   task automatic run_blk(input logic [23:0] psn, input logic au, input logic [7:0] fid,
      input logic [7:0] xfid, input logic ly, input logic [47:0] inf, input logic sl,
      input logic [9:0] fl, input logic [2:0] er);
      logic [23:0] a;
      logic [47:0] b;
      logic [127:0] blk;
      logic [11:0] w;
      logic ok;
      int f, k, p;
      a = {4'h_F, ~psn[23:4]};
      b = (xfid == 8'h_00) ? {a, ly, 7'h_00, 16'h_0000} : inf;
      blk = {a, rs({a, 32'h_0}, 3), xfid, b, rs({xfid, b}, 7)};
      @(negedge clock);
      cn = 10'h_000;
      dn = 10'h_000;
      fe_seen = 1'b0;
      bv_seen = 1'b0;
      @(posedge clock);
      enc_psn <= psn;
      enc_auto <= au;
      enc_field_id <= fid;
      enc_layer <= ly;
      enc_info <= inf;
      enc_start <= 1'b1;
      @(posedge clock);
      enc_start <= 1'b0;
      repeat (100) @(posedge clock);
      enc_start <= 1'b1;
      enc_psn <= ~psn;
      @(posedge clock);
      enc_start <= 1'b0;
      enc_psn <= psn;
      k = 0;
      while (enc_busy === 1'b1 && k < 800) begin
         @(negedge clock);
         k++;
      end
      repeat (2) @(negedge clock);
      chk({k < 800, dn, cn}, {1'b1, 10'h_27B, 10'h_27C});
      for (k = 0; k < 12; k++) w[11-k] = cap[k];
      chk(w, PFX_PATTERN);
      for (f = 0; f < 16; f++) begin
         p = 12 + 39 * f;
         ok = 1'b1;
         for (k = 1; k < 13; k++) begin
            ok = ok & (cap[p+3*k] === 1'b1) & (cap[p+3*k+1] === 1'b0);
            w = {w[10:0], cap[p+3*k+2]};
         end
         chk({cap[p], cap[p+1], cap[p+2], ok, w},
            {TRIP_SYNC, 1'b1, f[3:0], blk[127-8*f -: 8]});
      end
      @(posedge clock);
      play <= 1'b1;
      slow <= sl;
      flip <= fl;
      @(posedge clock);
      play <= 1'b0;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (m_busy === 1'b1 && k < 2000);
      repeat (8) @(negedge clock);
      chk({k < 2000, fe_seen}, {1'b1, er[2]});
      if (er == 3'h_0)
         chk({bv_seen, snap}, {1'b1, 2'h_0, b[23], xfid, a, b});
      else if (!er[2]) chk({bv_seen, snap[82:81]}, {1'b1, er[1:0]});
   endtask

   // ==================================================================
   // Scenarios
   task automatic t_data_zone();
      run_blk(24'h_03_0007, 1'b1, 8'h_55, 8'h_00, 1'b1, 48'h_0, 1'b0, 10'h_3FF, 3'h_0);
   endtask

   // Lead-in identifier cycle, then the first identifier-0 block and the last cycle block
   task automatic t_leadin();
      int k;
      for (k = 0; k < 5; k++) begin
         run_blk({~(20'h_FDBBB - k[19:0]), 4'h_3}, 1'b1, 8'h_00, 8'(k + 1), 1'b0,
            48'h_0, 1'b0, 10'h_3FF, 3'h_0);
      end
      run_blk({~20'h_FD003, 4'h_C}, 1'b1, 8'h_02, 8'h_00, 1'b0, 48'h_0, 1'b0, 10'h_3FF, 3'h_0);
      run_blk({~20'h_FD004, 4'h_0}, 1'b1, 8'h_00, 8'h_05, 1'b0, 48'h_0, 1'b0, 10'h_3FF, 3'h_0);
   endtask

   // Chosen identifiers with slow replay; identifier 0 ignores the info bytes
   task automatic t_manual();
      run_blk(24'h_12_345F, 1'b0, 8'h_03, 8'h_03, 1'b1, 48'h_1234_5678_9ABC, 1'b1,
         10'h_3FF, 3'h_0);
      run_blk(24'h_AB_CDE1, 1'b0, 8'h_00, 8'h_00, 1'b0, 48'h_FFFF_FFFF_FFFF, 1'b1,
         10'h_3FF, 3'h_0);
   endtask

   // Flipped data bit in each part, then a broken frame sync
   task automatic t_faults();
      run_blk(24'h_05_5550, 1'b0, 8'h_04, 8'h_04, 1'b0, 48'h_0102_0304_0506, 1'b0,
         10'h_044, 3'h_2);
      run_blk(24'h_05_5550, 1'b0, 8'h_04, 8'h_04, 1'b0, 48'h_0102_0304_0506, 1'b0,
         10'h_16A, 3'h_1);
      run_blk(24'h_05_5550, 1'b0, 8'h_04, 8'h_04, 1'b0, 48'h_0102_0304_0506, 1'b0,
         10'h_0CF, 3'h_4);
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      t_data_zone();
      t_leadin();
      t_manual();
      t_faults();
      stop_test();
   end

   // Watchdog against a hang
   initial begin
      #1200000;
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
